// *** sic_pkg.sv ***
/*
 * Package for the serial controller interrupt block: register offsets,
 * field positions, reset values and source indices.
 * Assumes a 32-bit classic Wishbone slave with word-aligned registers.
 */
package sic_pkg;
    localparam int          NUM_SRC        = 6;
    // Source indices, 0 is highest priority
    localparam int          SRC_A_RX       = 0;
    localparam int          SRC_A_TX       = 1;
    localparam int          SRC_A_EXT      = 2;
    localparam int          SRC_B_RX       = 3;
    localparam int          SRC_B_TX       = 4;
    localparam int          SRC_B_EXT      = 5;
    // Byte offsets
    localparam logic [7:0]  OFS_CTRL_A     = 8'h00;
    localparam logic [7:0]  OFS_CTRL_B     = 8'h04;
    localparam logic [7:0]  OFS_MASTER     = 8'h08;
    localparam logic [7:0]  OFS_PENDING    = 8'h0C;
    localparam logic [7:0]  OFS_COMMAND    = 8'h10;
    localparam logic [7:0]  OFS_IRQ_STAT   = 8'h14;
    localparam logic [7:0]  OFS_IRQ_MASK   = 8'h18;
    localparam logic [7:0]  OFS_MAIN_STAT  = 8'h1C;
    // irq_dma_control_reg fields
    localparam int          CTL_EXT_EN     = 0;
    localparam int          CTL_TX_EN      = 1;
    localparam int          CTL_PAR_SPEC   = 2;
    localparam int          CTL_RXM_LO     = 3;
    localparam int          CTL_RXM_HI     = 4;
    localparam int          CTL_WDMA_EN    = 7;
    // master_control_reg fields
    localparam int          MST_DLC        = 2;
    localparam int          MST_MIE        = 3;
    // Command register fields
    localparam int          CMD_RST_IUS    = 0;
    localparam int          CMD_CLR_BASE   = 8;
    // Receive interrupt modes
    localparam logic [1:0]  RXM_OFF        = 2'h0;
    localparam logic [1:0]  RXM_FIRST      = 2'h1;
    localparam logic [1:0]  RXM_ALL        = 2'h2;
    localparam logic [1:0]  RXM_SPECIAL    = 2'h3;
    // Reset values
    localparam logic [7:0]  CTRL_RST       = 8'h00;
    localparam logic [7:0]  MASTER_RST     = 8'h00;
    // Block-level status events
    localparam int          EV_ACK         = 0;
    localparam int          EV_EOS         = 1;
    localparam int          NUM_EV         = 2;
endpackage

// *** sic_prio.sv ***
/*
 * Fixed priority daisy chain over the six sources.
 * Assumes bit 0 is highest priority; purely combinational.
 */
`timescale 1ns/1ps
module sic_prio #(
    parameter int N = 6
) (
    input  wire logic [N-1:0] pend_i,
    input  wire logic [N-1:0] ius_i,
    output logic      [N-1:0] grant_o,
    output logic      [N-1:0] top_ius_o,
    output logic      [N-1:0] block_o
);
    logic [N:0] pend_seen;
    logic [N:0] ius_seen;
    assign pend_seen[0] = 1'b0;
    assign ius_seen[0]  = 1'b0;
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_chain
            assign grant_o[g]     = pend_i[g] & ~pend_seen[g] & ~ius_seen[g];
            assign top_ius_o[g]   = ius_i[g] & ~ius_seen[g];
            // A source is blocked by its own or any higher in-service bit
            assign block_o[g]     = ius_seen[g] | ius_i[g];
            assign pend_seen[g+1] = pend_seen[g] | pend_i[g];
            assign ius_seen[g+1]  = ius_seen[g] | ius_i[g];
        end
    endgenerate
endmodule // sic_prio

// *** sic_ctrl.sv ***
/*
 * Interrupt control for a two-channel serial controller: enables,
 * pending and in-service bits, open-drain request, external daisy chain.
 * Assumes classic Wishbone, 32-bit data, single clock; chain inputs
 * and acknowledge come from pins and are synchronised here.
 */
`timescale 1ns/1ps
// Functional notes
// - No request when both enables are zero
// - Master enable: pull request low when needed
// - Six sources, three per channel
// - Fixed priority A rx down to B ext
// - Each source: enable, pending, in-service
// - Disable-lower-chain stops lower chain devices
// - Disabled source never requests
// - Control bits: ext, tx, parity special
// - Receive mode field selects receive events
// - Pending set by event, cleared by host
// - Pending never set while disabled
// - Pending status readable, top bits zero
// - Acknowledge marks highest pending in service
// - In-service masks lower priority sources
// - Reset-highest command clears top in-service
// - Disable-lower-chain drives chain output low
module sic_ctrl (
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [1:0]  rx_char_i,
    input  wire logic [1:0]  rx_first_i,
    input  wire logic [1:0]  rx_special_i,
    input  wire logic [1:0]  rx_parity_i,
    input  wire logic [1:0]  tx_empty_i,
    input  wire logic [1:0]  ext_change_i,
    input  wire logic        chain_enable_in_i,
    input  wire logic        irq_acknowledge_in_n_i,
    output logic             irq_n_o,
    output logic             irq_n_oe_n_o,
    output logic             chain_enable_out_o,
    output logic [1:0]       wdma_enable_o,
    output logic             irq_o
);
    localparam int N = sic_pkg::NUM_SRC;

    typedef struct packed {
        logic [7:0]                 ctrl_a;
        logic [7:0]                 ctrl_b;
        logic [7:0]                 master;
        logic [N-1:0]               pend;
        logic [N-1:0]               source_in_service;
        logic [sic_pkg::NUM_EV-1:0] evst;
        logic [sic_pkg::NUM_EV-1:0] evmask;
        logic [2:0]                 iei_sync;
        logic [2:0]                 ack_sync;
        logic                       chain_enable_in;
        logic                       ack_act;
        logic                       ack_done;
        logic                       irq_oe_n;
        logic                       chain_enable_out;
        logic                       irq;
        logic [1:0]                 wdma;
        logic [31:0]                dat;
        logic                       wack;
    } sic_state_type;

    sic_state_type st_r;
    sic_state_type st_nxt;

    logic [N-1:0] grant;
    logic [N-1:0] top_ius;
    logic [N-1:0] block;
    logic [N-1:0] src_en;
    logic [N-1:0] src_ev;
    logic [N-1:0] req;
    logic         bus_req;
    logic         wr_hit;
    logic         rd_hit;
    logic         master_irq_enable;
    logic         disable_lower_chain;

    // Receive event under the selected mode
    function automatic logic rx_event(input logic [7:0] ctl, input logic chr,
                                      input logic first, input logic spec,
                                      input logic par);
        logic sp;
        logic [1:0] md;
        sp = spec | (par & ctl[sic_pkg::CTL_PAR_SPEC]);
        md = ctl[sic_pkg::CTL_RXM_HI:sic_pkg::CTL_RXM_LO];
        case (md)
            sic_pkg::RXM_OFF:     rx_event = 1'b0;
            sic_pkg::RXM_FIRST:   rx_event = first | sp;
            sic_pkg::RXM_ALL:     rx_event = chr | sp;
            sic_pkg::RXM_SPECIAL: rx_event = sp;
            default:              rx_event = 1'b0;
        endcase
    endfunction

    // Source enables in priority order
    function automatic logic [2:0] chan_en(input logic [7:0] ctl);
        chan_en = {ctl[sic_pkg::CTL_EXT_EN], ctl[sic_pkg::CTL_TX_EN],
                   ctl[sic_pkg::CTL_RXM_HI:sic_pkg::CTL_RXM_LO] != sic_pkg::RXM_OFF};
    endfunction

    sic_prio #(
        .N (N)
    ) u_prio (
        .pend_i    (st_r.pend),
        .ius_i     (st_r.source_in_service),
        .grant_o   (grant),
        .top_ius_o (top_ius),
        .block_o   (block)
    );

    assign master_irq_enable     = st_r.master[sic_pkg::MST_MIE];
    assign disable_lower_chain     = st_r.master[sic_pkg::MST_DLC];
    assign bus_req = wb_cyc_i & wb_stb_i & ~st_r.wack;
    assign wr_hit  = bus_req & wb_we_i & wb_sel_i[0];
    assign rd_hit  = bus_req & ~wb_we_i;
    assign src_en  = {chan_en(st_r.ctrl_b), chan_en(st_r.ctrl_a)};
    assign src_ev  = {ext_change_i[1], tx_empty_i[1],
                      rx_event(st_r.ctrl_b, rx_char_i[1], rx_first_i[1],
                               rx_special_i[1], rx_parity_i[1]),
                      ext_change_i[0], tx_empty_i[0],
                      rx_event(st_r.ctrl_a, rx_char_i[0], rx_first_i[0],
                               rx_special_i[0], rx_parity_i[0])};
    // Pending, enabled, not masked by in-service
    assign req     = st_r.pend & src_en & ~block;

    always_comb begin
        st_nxt = st_r;
        st_nxt.iei_sync = {st_r.iei_sync[1:0], chain_enable_in_i};
        st_nxt.ack_sync = {st_r.ack_sync[1:0], ~irq_acknowledge_in_n_i};
        if (st_r.iei_sync[2] == st_r.iei_sync[1]) begin
            st_nxt.chain_enable_in = st_r.iei_sync[2];
        end
        if (st_r.ack_sync[2] == st_r.ack_sync[1]) begin
            st_nxt.ack_act = st_r.ack_sync[2];
        end
        if (!st_r.ack_act) begin
            st_nxt.ack_done = 1'b0;
        end
        st_nxt.wack = bus_req;
        st_nxt.dat  = 32'h0000_0000;
        // Bus writes
        if (wr_hit) begin
            case (wb_adr_i)
                sic_pkg::OFS_CTRL_A: st_nxt.ctrl_a = wb_dat_i[7:0];
                sic_pkg::OFS_CTRL_B: st_nxt.ctrl_b = wb_dat_i[7:0];
                sic_pkg::OFS_MASTER: st_nxt.master = wb_dat_i[7:0];
                sic_pkg::OFS_COMMAND: begin
                    if (wb_dat_i[sic_pkg::CMD_RST_IUS]) begin
                        st_nxt.source_in_service = st_r.source_in_service & ~top_ius;
                    end
                    if (wb_sel_i[1]) begin
                        st_nxt.pend = st_r.pend &
                            ~wb_dat_i[sic_pkg::CMD_CLR_BASE +: N];
                    end
                end
                sic_pkg::OFS_IRQ_STAT:
                    st_nxt.evst = st_r.evst & ~wb_dat_i[sic_pkg::NUM_EV-1:0];
                sic_pkg::OFS_IRQ_MASK:
                    st_nxt.evmask = wb_dat_i[sic_pkg::NUM_EV-1:0];
                default: ;
            endcase
        end
        // Events set pending after the clear, so set wins
        st_nxt.pend = (st_nxt.pend | (src_ev & src_en)) & src_en;
        if (wr_hit && wb_adr_i == sic_pkg::OFS_COMMAND &&
            wb_dat_i[sic_pkg::CMD_RST_IUS] && |top_ius) begin
            st_nxt.evst[sic_pkg::EV_EOS] = 1'b1;
        end
        // Acknowledge: highest pending source goes in service
        if (st_r.ack_act && !st_r.ack_done && master_irq_enable && st_r.chain_enable_in && |(grant & src_en)) begin
            st_nxt.source_in_service      = st_nxt.source_in_service | (grant & src_en);
            st_nxt.ack_done = 1'b1;
            st_nxt.evst[sic_pkg::EV_ACK] = 1'b1;
        end
        if (rd_hit) begin
            case (wb_adr_i)
                sic_pkg::OFS_CTRL_A:    st_nxt.dat = 32'h0000_0000;
                sic_pkg::OFS_MASTER:    st_nxt.dat = {24'h00_0000, st_r.master};
                sic_pkg::OFS_PENDING:   st_nxt.dat = {26'h000_0000,
                    st_r.pend[sic_pkg::SRC_A_RX], st_r.pend[sic_pkg::SRC_A_TX],
                    st_r.pend[sic_pkg::SRC_A_EXT], st_r.pend[sic_pkg::SRC_B_RX],
                    st_r.pend[sic_pkg::SRC_B_TX], st_r.pend[sic_pkg::SRC_B_EXT]};
                sic_pkg::OFS_IRQ_STAT:  st_nxt.dat = {30'h0000_0000, st_r.evst};
                sic_pkg::OFS_IRQ_MASK:  st_nxt.dat = {30'h0000_0000, st_r.evmask};
                sic_pkg::OFS_MAIN_STAT: st_nxt.dat = {26'h000_0000, src_ev};
                default:                st_nxt.dat = 32'h0000_0000;
            endcase
        end
        // Open-drain request, low only while something needs service
        st_nxt.irq_oe_n = ~(master_irq_enable & st_r.chain_enable_in & ~st_r.ack_act & |req);
        // Chain output low on disable, or with master enable on pending or in-service
        st_nxt.chain_enable_out  = st_r.chain_enable_in & ~disable_lower_chain & ~(master_irq_enable & |(st_r.source_in_service | req));
        st_nxt.irq  = |(st_nxt.evst & st_nxt.evmask);
        st_nxt.wdma = {st_r.ctrl_b[sic_pkg::CTL_WDMA_EN],
                       st_r.ctrl_a[sic_pkg::CTL_WDMA_EN]};
        if (srst_i) begin
            st_nxt        = '0;
            st_nxt.ctrl_a = sic_pkg::CTRL_RST;
            st_nxt.ctrl_b = sic_pkg::CTRL_RST;
            st_nxt.master = sic_pkg::MASTER_RST;
            st_nxt.irq_oe_n = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        st_r <= st_nxt;
    end

    assign wb_dat_o           = st_r.dat;
    assign wb_ack_o           = st_r.wack;
    assign irq_n_o            = 1'b0;
    assign irq_n_oe_n_o       = st_r.irq_oe_n;
    assign chain_enable_out_o = st_r.chain_enable_out;
    assign wdma_enable_o      = st_r.wdma;
    assign irq_o              = st_r.irq;

    AST_POLLED_QUIET: assert property (@(posedge clk_i) disable iff (srst_i)
        !master_irq_enable |=> irq_n_oe_n_o) else $error("request while master enable clear");
    AST_DLC_LOW: assert property (@(posedge clk_i) disable iff (srst_i)
        disable_lower_chain |=> !chain_enable_out_o) else $error("chain out high with lower chain off");
    AST_PEND_DIS: assert property (@(posedge clk_i) disable iff (srst_i)
        ##1 ((st_r.pend & ~src_en) == '0)) else $error("pending set while disabled");
    AST_IUS_ONE: assert property (@(posedge clk_i) disable iff (srst_i)
        $rose(|st_r.source_in_service) |-> $onehot(st_r.source_in_service)) else $error("several in-service set at once");
    AST_RST_IUS: assert property (@(posedge clk_i) disable iff (srst_i)
        (wr_hit && wb_adr_i == sic_pkg::OFS_COMMAND && wb_dat_i[sic_pkg::CMD_RST_IUS]
         && !st_r.ack_act) |=> (st_r.source_in_service == ($past(st_r.source_in_service) & ~$past(top_ius))))
        else $error("reset-highest did not clear top in-service");
    AST_REQ_RELEASE: assert property (@(posedge clk_i) disable iff (srst_i)
        (req == '0) |=> irq_n_oe_n_o) else $error("request held with nothing pending");
    AST_REQ_ASSERT: assert property (@(posedge clk_i) disable iff (srst_i)
        (master_irq_enable && st_r.chain_enable_in && !st_r.ack_act && |req) |=> !irq_n_oe_n_o)
        else $error("no request while service needed");
    AST_ACK_ONCE: assert property (@(posedge clk_i) disable iff (srst_i)
        (|st_r.source_in_service && !wr_hit) |=> ((st_r.source_in_service & ~$past(st_r.source_in_service)) == '0 ||
         $past(st_r.ack_act))) else $error("in-service set outside acknowledge");
    AST_WB_ACK: assert property (@(posedge clk_i) disable iff (srst_i)
        wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
endmodule // sic_ctrl

// *** sic_far_model.sv ***
/*
 * Far-side model: host acknowledge, upstream chain and request pull-up.
 * Assumes the same clock as the block; bench starts each acknowledge.
 */
`timescale 1ns/1ps
module sic_far_model (
    input  wire logic clk_i,
    input  wire logic ack_go_i,
    input  wire logic chain_hi_i,
    input  wire logic irq_n_i,
    input  wire logic irq_n_oe_n_i,
    output logic      chain_enable_in_o,
    output logic      irq_acknowledge_in_n_o,
    output logic      irq_line_o
);
    int ack_cnt = 0;
    initial irq_acknowledge_in_n_o = 1'h1;
    // Pull-up holds the shared line high when released
    assign irq_line_o = irq_n_oe_n_i ? 1'h1 : irq_n_i;
    assign chain_enable_in_o = chain_hi_i;
    // Acknowledge only a live request, long enough for the input filter
    always @(posedge clk_i) begin
        if (ack_go_i && ack_cnt == 0 && irq_line_o == 1'h0) begin
            ack_cnt <= 6;
        end else if (ack_cnt != 0) begin
            ack_cnt <= ack_cnt - 1;
        end
        irq_acknowledge_in_n_o <= (ack_cnt == 0);
    end
endmodule // sic_far_model

// *** sic_ctrl_test.sv ***
/*
 * Self-checking bench for the interrupt control block.
 * Assumes sic_far_model on the host side and classic Wishbone registers.
 */
`timescale 1ns/1ps
module sic_ctrl_test;
    logic        clk_i = 1'h0;
    logic        srst_i = 1'h1;
    logic        cyc = 1'h0;
    logic        stb = 1'h0;
    logic        we = 1'h0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [11:0] ev = 12'h000;
    logic        ack_go = 1'h0;
    logic        chain_hi = 1'h1;
    logic        ack, chain_in, irq_acknowledge_in_n, irq_n, oe_n, chain_out, irq, line;
    logic [31:0] rdat, q;
    logic [1:0]  wdma;
    int          n_mismatch = 0;
    int          cmp_count = 0;
    int          cyc_n = 0;

    sic_ctrl sic_ctrl_inst (
        .clk_i(clk_i), .srst_i(srst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .rx_char_i(ev[1:0]),
        .rx_first_i(ev[3:2]), .rx_special_i(ev[5:4]), .rx_parity_i(ev[7:6]),
        .tx_empty_i(ev[9:8]), .ext_change_i(ev[11:10]),
        .chain_enable_in_i(chain_in), .irq_acknowledge_in_n_i(irq_acknowledge_in_n),
        .irq_n_o(irq_n), .irq_n_oe_n_o(oe_n), .chain_enable_out_o(chain_out),
        .wdma_enable_o(wdma), .irq_o(irq));
    sic_far_model sic_far_model_inst (
        .clk_i(clk_i), .ack_go_i(ack_go), .chain_hi_i(chain_hi), .irq_n_i(irq_n),
        .irq_n_oe_n_i(oe_n), .chain_enable_in_o(chain_in),
        .irq_acknowledge_in_n_o(irq_acknowledge_in_n), .irq_line_o(line));

    always #2.5 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 20000) begin
            n_mismatch++;
            test_done();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        dat <= d;
        // Ack and read data taken at the rising edge that samples ack high
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'h1 && n < 50);
        if (n >= 50) chk("bus ack", 32'h1, 32'h0);
        q = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        wb(1'h0, a, 32'h0);
        chk(nm, e, q);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'h1, a, d);
    endtask

    task automatic pulse(input logic [11:0] v);
        @(posedge clk_i);
        ev <= v;
        @(posedge clk_i);
        ev <= 12'h000;
        repeat (2) @(posedge clk_i);
    endtask

    task automatic ln(input logic e, input string nm);
        repeat (12) @(posedge clk_i);
        @(negedge clk_i);
        chk(nm, {31'h0, e}, {31'h0, line});
    endtask

    task automatic acknowledge();
        @(posedge clk_i);
        ack_go <= 1'h1;
        @(posedge clk_i);
        ack_go <= 1'h0;
    endtask

    task automatic t_reset();
        ln(1'h0 ^ 1'h1, "request idle");
        chk("chain out", 32'h1, {31'h0, chain_out});
        rd(sic_pkg::OFS_PENDING, 32'h0, "pending");
        rd(sic_pkg::OFS_MASTER, 32'h0, "master");
        rd(sic_pkg::OFS_CTRL_A, 32'h0, "ctrl write only");
        rd(8'h20, 32'h0, "unmapped");
        $display("test reset done");
    endtask

    task automatic t_polled();
        pulse(12'hFFF);
        rd(sic_pkg::OFS_PENDING, 32'h0, "pending disabled");
        ln(1'h1, "polled idle");
        ev <= 12'h100;
        rd(sic_pkg::OFS_MAIN_STAT, 32'h2, "main status");
        ev <= 12'h000;
        $display("test polled done");
    endtask

    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            wr(sic_pkg::OFS_CTRL_A, 32'(m << 3) | 32'h4);
            pulse(12'h005);
            rd(sic_pkg::OFS_PENDING, (m == 1 || m == 2) ? 32'h20 : 32'h0, "rx char");
            wr(sic_pkg::OFS_COMMAND, 32'h3F00);
            pulse(12'h010);
            rd(sic_pkg::OFS_PENDING, (m != 0) ? 32'h20 : 32'h0, "rx special");
            wr(sic_pkg::OFS_COMMAND, 32'h3F00);
            pulse(12'h040);
            rd(sic_pkg::OFS_PENDING, (m != 0) ? 32'h20 : 32'h0, "parity");
            wr(sic_pkg::OFS_COMMAND, 32'h3F00);
        end
        wr(sic_pkg::OFS_CTRL_A, 32'h18);
        pulse(12'h040);
        rd(sic_pkg::OFS_PENDING, 32'h0, "parity off");
        $display("test modes done");
    endtask

    task automatic t_irq();
        wr(sic_pkg::OFS_IRQ_MASK, 32'h3);
        wr(sic_pkg::OFS_CTRL_A, 32'h13);
        wr(sic_pkg::OFS_CTRL_B, 32'h93);
        @(negedge clk_i);
        chk("wdma", 32'h2, {30'h0, wdma});
        pulse(12'hF0F);
        rd(sic_pkg::OFS_PENDING, 32'h3F, "all pending");
        ln(1'h1, "no master enable");
        wr(sic_pkg::OFS_MASTER, 32'h8);
        ln(1'h0, "request");
        wr(sic_pkg::OFS_MASTER, 32'hC);
        ln(1'h0, "request dlc");
        chk("chain dlc", 32'h0, {31'h0, chain_out});
        acknowledge();
        ln(1'h1, "rx in service");
        wr(sic_pkg::OFS_COMMAND, 32'h100);
        ln(1'h1, "lower masked");
        wr(sic_pkg::OFS_COMMAND, 32'h1);
        ln(1'h0, "next source");
        acknowledge();
        ln(1'h1, "tx in service");
        wr(sic_pkg::OFS_COMMAND, 32'h200);
        ln(1'h1, "channel b masked");
        wr(sic_pkg::OFS_COMMAND, 32'h1);
        ln(1'h0, "ext next");
        rd(sic_pkg::OFS_IRQ_STAT, 32'h3, "events");
        chk("irq raised", 32'h1, {31'h0, irq});
        wr(sic_pkg::OFS_IRQ_MASK, 32'h0);
        @(negedge clk_i);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(sic_pkg::OFS_IRQ_MASK, 32'h3);
        wr(sic_pkg::OFS_IRQ_STAT, 32'h3);
        @(negedge clk_i);
        chk("irq cleared", 32'h0, {31'h0, irq});
        rd(sic_pkg::OFS_IRQ_STAT, 32'h0, "events cleared");
        wr(sic_pkg::OFS_MASTER, 32'h4);
        ln(1'h1, "master off");
        wr(sic_pkg::OFS_MASTER, 32'h8);
        ln(1'h0, "master on");
        chk("chain held by pending", 32'h0, {31'h0, chain_out});
        @(posedge clk_i);
        chain_hi <= 1'h0;
        ln(1'h1, "chain in low");
        chk("chain in low out", 32'h0, {31'h0, chain_out});
        @(posedge clk_i);
        chain_hi <= 1'h1;
        ln(1'h0, "chain in back");
        wr(sic_pkg::OFS_COMMAND, 32'h3F00);
        rd(sic_pkg::OFS_PENDING, 32'h0, "cleared");
        ln(1'h1, "nothing left");
        chk("chain on", 32'h1, {31'h0, chain_out});
        $display("test irq done");
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge clk_i);
        srst_i <= 1'h0;
        t_reset();
        t_polled();
        t_modes();
        t_irq();
        test_done();
    end
endmodule // sic_ctrl_test
